// file: legacy_decode_pkg.sv
// legacy_decode_pkg: offsets, reset values, field positions and types for the legacy decode block
// assumes a plain register port with byte-wide registers at configuration offsets
package legacy_decode_pkg;

  // register offsets
  localparam logic [7:0] ATTR_MAP_BASE_OFS = 8'h90; // seven attribute map bytes 90..96
  localparam logic [7:0] ATTR_MAP_LAST_OFS = 8'h96;
  localparam logic [7:0] FIXED_HOLE_OFS = 8'h97;
  localparam logic [7:0] SMM_RAM_OFS = 8'h9d;

  // reset values
  localparam logic [7:0] FIXED_HOLE_RST = 8'h00;
  localparam logic [7:0] SMM_RAM_RST = 8'h02;
  localparam logic [7:0] ATTR_MAP_RST = 8'h00;

  // field positions
  localparam int HOLE_EN_BIT = 7;
  localparam int SMM_OPEN_BIT = 6;
  localparam int SMM_CLOSED_BIT = 5;
  localparam int SMM_LOCK_BIT = 4;
  localparam int SMM_GLOBAL_BIT = 3;
  localparam logic [2:0] BASE_SEG_VAL = 3'h2; // fixed base segment code

  // address windows (20/32-bit byte addresses)
  localparam logic [31:0] LOW_DOS_TOP = 32'h0007_ffff;
  localparam logic [31:0] HI_DOS_BASE = 32'h0008_0000;
  localparam logic [31:0] HI_DOS_TOP = 32'h0009_ffff;
  localparam logic [31:0] VIDEO_BASE = 32'h000a_0000;
  localparam logic [31:0] VIDEO_TOP = 32'h000b_ffff;
  localparam logic [31:0] EXP_BASE = 32'h000c_0000;
  localparam logic [31:0] EXT_BIOS_TOP = 32'h000e_ffff;
  localparam logic [31:0] SYS_BIOS_BASE = 32'h000f_0000;
  localparam logic [31:0] SYS_BIOS_TOP = 32'h000f_ffff;
  localparam logic [31:0] ISA_HOLE_BASE = 32'h00f0_0000;
  localparam logic [31:0] ISA_HOLE_TOP = 32'h00ff_ffff;
  localparam int SEG_SHIFT = 14; // 16 KB segments
  localparam int SEG_COUNT = 12; // eight expansion plus four extended bios
  localparam int ATTR_REGS = 7;

  // access routing targets
  typedef enum logic [2:0]
  {
    DEST_DRAM = 3'h0,
    DEST_PCI = 3'h1,
    DEST_AGP = 3'h2,
    DEST_HUB = 3'h3,
    DEST_REFUSE = 3'h4
  } dest_t;

  // access initiator
  typedef enum logic [1:0]
  {
    SRC_HOST = 2'h0,
    SRC_HUB = 2'h1,
    SRC_AGP = 2'h2,
    SRC_PCI = 2'h3
  } src_t;

  // incoming access request
  typedef struct packed
  {
    logic valid;
    logic [31:0] addr;
    logic write;
    logic code;   // code fetch rather than data reference
    logic smm;    // smm decode active on this cycle
    src_t src;
  } access_req_t;

  // routing answer
  typedef struct packed
  {
    logic valid;
    dest_t dest;
  } access_rsp_t;

  // register port
  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // smm control decoded for routing
  typedef struct packed
  {
    logic global_on;
    logic open;
    logic closed;
    logic lock;
  } smm_ctl_t;

endpackage : legacy_decode_pkg

// file: segment_attr_decode.sv
// segment_attr_decode: turns one 2-bit read/write attribute into a host destination
// assumes the attribute nibble has write enable at bit 1 and read enable at bit 0
`timescale 1ns/1ps
module segment_attr_decode
  import legacy_decode_pkg::*;
(
  input wire logic [1:0] i_attr,
  input wire logic i_write,
  output legacy_decode_pkg::dest_t o_dest
);
  // enabled direction goes to dram, disabled direction to the hub link
  always_comb
  begin
    if (i_write)
      o_dest = i_attr[1] ? DEST_DRAM : DEST_HUB;
    else
      o_dest = i_attr[0] ? DEST_DRAM : DEST_HUB;
  end
endmodule : segment_attr_decode

// file: smm_ctl_reg.sv
// smm_ctl_reg: smm ram control byte with lock behaviour
// assumes writes arrive as one-cycle strobes with a byte of data
`timescale 1ns/1ps
module smm_ctl_reg
  import legacy_decode_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_value,
  output legacy_decode_pkg::smm_ctl_t o_ctl
);
  typedef struct packed
  {
    logic open;
    logic closed;
    logic lock;
    logic global_on;
  } smm_state_t;

  smm_state_t state_q;
  smm_state_t state_d;

  // next state of the control bits
  always_comb
  begin
    state_d = state_q;
    if (i_wr)
    begin
      state_d.closed = i_wdata[SMM_CLOSED_BIT];
      if (!state_q.lock)
      begin
        state_d.global_on = i_wdata[SMM_GLOBAL_BIT];
        state_d.open = i_wdata[SMM_OPEN_BIT];
        state_d.lock = i_wdata[SMM_LOCK_BIT];
        if (i_wdata[SMM_LOCK_BIT])
          state_d.open = 1'b0;
      end
    end
  end

  // lock clears only on reset
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_q <= '{open: SMM_RAM_RST[SMM_OPEN_BIT], closed: SMM_RAM_RST[SMM_CLOSED_BIT],
                   lock: SMM_RAM_RST[SMM_LOCK_BIT], global_on: SMM_RAM_RST[SMM_GLOBAL_BIT]};
    else
      state_q <= state_d;
  end

  // readback with fixed base segment
  assign o_value = {1'b0, state_q.open, state_q.closed, state_q.lock, state_q.global_on,
                    BASE_SEG_VAL};
  assign o_ctl = '{global_on: state_q.global_on, open: state_q.open,
                   closed: state_q.closed, lock: state_q.lock};
endmodule : smm_ctl_reg

// file: legacy_region_smm_ram_control_decode.sv
// legacy_region_smm_ram_control_decode: routes accesses below 1 MB and in the 15-16 MB hole
// assumes one access per cycle, answered one cycle later; registers on a plain byte port
//
// Operation
// - lowest 512 KB always goes to dram.
// - 80000h-9FFFFh goes to dram unless declared a hole, then pci.
// - video range ignores segment attributes; routed to pci or agp by vga control.
// - smm-configured video range refuses hub link and agp initiators.
// - C0000h-DFFFFh decodes as eight 16 KB segments with own attributes.
// - E0000h-EFFFFh decodes as four 16 KB segments with own attributes.
// - F0000h-FFFFFh is one 64 KB segment with one attribute.
// - hole enable bit 7 sends 15-16 MB away from dram, no remap.
// - open, closed and lock affect routing only with global smm enable set.
// - open without lock shows smm dram to non-smm host accesses.
// - closed denies data references in smm; code still reaches dram.
// - writing lock clears open and freezes lock, open, global fields.
// - lock set by normal write stays until reset.
// - global enable maps 128 KB dram at A0000h for smm; frozen by lock.
// - bits 2:0 read 010; failed smm access forwards to hub link.
// - read-only segment: host reads to dram, host writes to hub link; non-host to dram.
`timescale 1ns/1ps
module legacy_region_smm_ram_control_decode
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input legacy_decode_pkg::reg_req_t i_reg,
  output logic [7:0] o_reg_rdata,
  input legacy_decode_pkg::access_req_t i_acc,
  input wire logic i_vga_to_agp,
  output legacy_decode_pkg::access_rsp_t o_rsp
);
  import legacy_decode_pkg::*;

  typedef struct packed
  {
    logic hole_en;
    logic [ATTR_REGS-1:0][7:0] attr_map;
    logic [7:0] rdata;
    access_rsp_t rsp;
  } top_state_t;

  top_state_t st_q;
  top_state_t st_d;
  logic [7:0] smm_value;
  smm_ctl_t smm_ctl;
  logic smm_wr;
  logic [SEG_COUNT-1:0][1:0] seg_attr;
  dest_t [SEG_COUNT-1:0] seg_dest;
  dest_t bios_dest;
  logic [3:0] seg_idx;
  logic [2:0] attr_idx;
  logic [31:0] a;
  dest_t dest;
  logic video_dram;
  logic video_smm;

  assign smm_wr = i_reg.wr && (i_reg.addr == SMM_RAM_OFS);

  // smm control register with lock
  smm_ctl_reg u_smm
  (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_wr(smm_wr),
    .i_wdata(i_reg.wdata),
    .o_value(smm_value),
    .o_ctl(smm_ctl)
  );

  // segment attribute pairs: reg n low nibble = even seg, high nibble = odd seg
  genvar g;
  generate
    for (g = 0; g < SEG_COUNT; g++)
    begin : g_seg
      assign seg_attr[g] = (g % 2 == 0) ? st_q.attr_map[g/2 + 1][1:0]
                                        : st_q.attr_map[g/2 + 1][5:4];
      segment_attr_decode u_seg
      (
        .i_attr(seg_attr[g]),
        .i_write(i_acc.write),
        .o_dest(seg_dest[g])
      );
    end
  endgenerate

  // single bios segment
  segment_attr_decode u_bios
  (
    .i_attr(st_q.attr_map[0][5:4]),
    .i_write(i_acc.write),
    .o_dest(bios_dest)
  );

  assign a = i_acc.addr;
  assign seg_idx = 4'((a - EXP_BASE) >> SEG_SHIFT);
  assign attr_idx = 3'(i_reg.addr - ATTR_MAP_BASE_OFS);

  // video range smm conditions
  always_comb
  begin
    video_smm = smm_ctl.global_on;
    video_dram = smm_ctl.global_on && !(smm_ctl.closed && !i_acc.code)
                 && (i_acc.smm || (smm_ctl.open && !smm_ctl.lock));
  end

  // address decode
  always_comb
  begin
    dest = DEST_DRAM;
    if (a <= LOW_DOS_TOP)
      dest = DEST_DRAM;
    else if (a >= HI_DOS_BASE && a <= HI_DOS_TOP)
      dest = st_q.hole_en ? DEST_PCI : DEST_DRAM;
    else if (a >= VIDEO_BASE && a <= VIDEO_TOP)
    begin
      if (video_smm && (i_acc.src == SRC_HUB || i_acc.src == SRC_AGP))
        dest = DEST_REFUSE;
      else if (i_acc.src != SRC_HOST)
        dest = i_vga_to_agp ? DEST_AGP : DEST_PCI;
      else if (video_dram)
        dest = DEST_DRAM;
      else if (video_smm && i_acc.smm)
        dest = DEST_HUB;
      else
        dest = i_vga_to_agp ? DEST_AGP : DEST_PCI;
    end
    else if (a >= EXP_BASE && a <= EXT_BIOS_TOP)
      dest = (i_acc.src == SRC_HOST) ? seg_dest[seg_idx] : DEST_DRAM;
    else if (a >= SYS_BIOS_BASE && a <= SYS_BIOS_TOP)
      dest = (i_acc.src == SRC_HOST) ? bios_dest : DEST_DRAM;
    else if (a >= ISA_HOLE_BASE && a <= ISA_HOLE_TOP && st_q.hole_en)
      dest = DEST_PCI;
  end

  // register port and registered answer
  always_comb
  begin
    st_d = st_q;
    st_d.rsp.valid = i_acc.valid;
    st_d.rsp.dest = i_acc.valid ? dest : DEST_DRAM;
    st_d.rdata = 8'h00;
    if (i_reg.wr)
    begin
      if (i_reg.addr == FIXED_HOLE_OFS)
        st_d.hole_en = i_reg.wdata[HOLE_EN_BIT];
      else if (i_reg.addr >= ATTR_MAP_BASE_OFS && i_reg.addr <= ATTR_MAP_LAST_OFS)
        st_d.attr_map[attr_idx] = (attr_idx == 3'h0) ? (i_reg.wdata & 8'h30)
                                                    : (i_reg.wdata & 8'h33);
    end
    if (i_reg.rd)
    begin
      if (i_reg.addr == FIXED_HOLE_OFS)
        st_d.rdata = {st_q.hole_en, 7'h00};
      else if (i_reg.addr == SMM_RAM_OFS)
        st_d.rdata = smm_value;
      else if (i_reg.addr >= ATTR_MAP_BASE_OFS && i_reg.addr <= ATTR_MAP_LAST_OFS)
        st_d.rdata = st_q.attr_map[attr_idx];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_q.hole_en <= FIXED_HOLE_RST[HOLE_EN_BIT];
      st_q.attr_map <= {ATTR_REGS{ATTR_MAP_RST}};
      st_q.rdata <= 8'h00;
      st_q.rsp <= '{valid: 1'b0, dest: DEST_DRAM};
    end
    else
      st_q <= st_d;
  end

  assign o_reg_rdata = st_q.rdata;
  assign o_rsp = st_q.rsp;
endmodule : legacy_region_smm_ram_control_decode

// file: legacy_decode_chk.sv
// legacy_decode_chk: port-level checks of routing and smm control reads
// assumes bind onto legacy_region_smm_ram_control_decode, single core clock domain
`timescale 1ns/1ps
module legacy_decode_chk
  import legacy_decode_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input legacy_decode_pkg::reg_req_t i_reg,
  input wire logic [7:0] o_reg_rdata,
  input legacy_decode_pkg::access_req_t i_acc,
  input wire logic i_vga_to_agp,
  input legacy_decode_pkg::access_rsp_t o_rsp
);
  logic hole_q, open_q, cls_q, lock_q, glb_q;
  wire wr_smm = i_reg.wr && i_reg.addr == SMM_RAM_OFS;
  wire vid = i_acc.valid && i_acc.addr >= VIDEO_BASE && i_acc.addr <= VIDEO_TOP;
  wire host = i_acc.src == SRC_HOST;
  wire [7:0] smm_byte = {1'b0, open_q, cls_q, lock_q, glb_q, BASE_SEG_VAL};

  // shadow of hole enable and smm control, lock freezes all smm fields but closed
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      {hole_q, open_q, cls_q, lock_q, glb_q} <= 5'h00;
    else
    begin
      if (i_reg.wr && i_reg.addr == FIXED_HOLE_OFS)
        hole_q <= i_reg.wdata[7];
      if (wr_smm)
        cls_q <= i_reg.wdata[5];
      if (wr_smm && !lock_q)
      begin
        open_q <= i_reg.wdata[6] & ~i_reg.wdata[4];
        lock_q <= i_reg.wdata[4];
        glb_q <= i_reg.wdata[3];
      end
    end
  end

  default clocking dc @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  low_dram_a:
    assert property (i_acc.valid && i_acc.addr <= LOW_DOS_TOP |=> o_rsp.dest == DEST_DRAM)
    else $error("low area not routed to dram");
  dos_hole_a:
    assert property (i_acc.valid && hole_q && i_acc.addr >= HI_DOS_BASE
      && i_acc.addr <= HI_DOS_TOP |=> o_rsp.dest == DEST_PCI)
    else $error("dos hole access not sent to pci");
  hole_read_a:
    assert property (i_reg.rd && i_reg.addr == FIXED_HOLE_OFS |=> o_reg_rdata == {hole_q, 7'h00})
    else $error("hole control read wrong");
  smm_read_a:
    assert property (i_reg.rd && i_reg.addr == SMM_RAM_OFS |=> o_reg_rdata == smm_byte)
    else $error("smm control read wrong");
  hole_route_a:
    assert property (i_acc.valid && hole_q && i_acc.addr >= ISA_HOLE_BASE
      && i_acc.addr <= ISA_HOLE_TOP |=> o_rsp.valid ##0 o_rsp.dest == DEST_PCI)
    else $error("hole access not sent away");
  vga_route_a:
    assert property (vid && host && !glb_q
      |=> o_rsp.dest == ($past(i_vga_to_agp) ? DEST_AGP : DEST_PCI))
    else $error("video access off vga route");
  smm_refuse_a:
    assert property (vid && glb_q && (i_acc.src == SRC_HUB || i_acc.src == SRC_AGP)
      |=> o_rsp.dest == DEST_REFUSE)
    else $error("smm video not refused");
  smm_dram_a:
    assert property (vid && host && glb_q && (i_acc.code || !cls_q)
      && (i_acc.smm || (open_q && !lock_q)) |=> o_rsp.dest == DEST_DRAM)
    else $error("smm video not in dram");
  closed_data_a:
    assert property (vid && host && glb_q && cls_q && i_acc.smm && !i_acc.code
      |=> o_rsp.dest == DEST_HUB)
    else $error("closed data reference not denied");

  // main scenarios reached
  cover property (vid && host && i_acc.smm && glb_q);
  cover property (wr_smm && i_reg.wdata[4] && !lock_q);
  cover property (i_acc.valid && hole_q && i_acc.addr >= ISA_HOLE_BASE);
endmodule : legacy_decode_chk

bind legacy_region_smm_ram_control_decode legacy_decode_chk u_chk (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_reg(i_reg), .o_reg_rdata(o_reg_rdata),
  .i_acc(i_acc), .i_vga_to_agp(i_vga_to_agp), .o_rsp(o_rsp));

// file: host_bus_model.sv
// host_bus_model: processor-side master presenting one access per call
// assumes the block answers exactly one cycle after the request edge
`timescale 1ns/1ps
module host_bus_model
  import legacy_decode_pkg::*;
(
  input wire logic i_core_clk,
  input legacy_decode_pkg::access_rsp_t i_rsp,
  output legacy_decode_pkg::access_req_t o_acc
);
  initial o_acc = '0;

  // hold the request one edge, then scramble the released lines
  task automatic issue(input access_req_t req, output access_rsp_t rsp);
    access_req_t idle;
    idle = ~req;
    idle.valid = 1'b0;
    o_acc <= req;
    @(posedge i_core_clk);
    o_acc <= idle;
    #1 rsp = i_rsp;
    @(posedge i_core_clk);
  endtask : issue
endmodule : host_bus_model

// file: testbench.sv
// testbench: register and access stimulus with expected routing worked out here
// assumes host_bus_model on the access port and a 200 MHz core clock
`timescale 1ns/1ps
module testbench;
  import legacy_decode_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  reg_req_t rq = '0;
  logic vga = 1'b0;
  logic [7:0] rdata;
  access_req_t acc;
  access_rsp_t rsp;
  logic [31:0] seed = 32'h0000_0020;
  logic [31:0] r;
  logic [31:0] a;
  int n_fail = 0;
  int num_checks = 0;

  always #2.5 i_core_clk = ~i_core_clk;

  legacy_region_smm_ram_control_decode u_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_reg(rq),
    .o_reg_rdata(rdata), .i_acc(acc), .i_vga_to_agp(vga), .o_rsp(rsp));
  host_bus_model u_host (.i_core_clk(i_core_clk), .i_rsp(rsp), .o_acc(acc));

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift

  task automatic report(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : report

  // routing answer: valid must stand beside the expected destination
  task automatic check_route(input access_rsp_t got, input dest_t exp);
    access_rsp_t want;
    want = '{valid: 1'b1, dest: exp};
    num_checks++;
    if (got !== want)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : check_route

  // one write, one read, each followed by an idle edge
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    rq <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_core_clk);
    rq <= '0;
    @(posedge i_core_clk);
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    rq <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_core_clk);
    rq <= '0;
    #1 report(rdata, exp);
    @(posedge i_core_clk);
  endtask : rd

  // wcs packs write, code, smm
  task automatic go(input logic [31:0] ad, input logic [2:0] wcs, input src_t s, input dest_t e);
    access_rsp_t got;
    u_host.issue('{valid: 1'b1, addr: ad, write: wcs[2], code: wcs[1], smm: wcs[0], src: s}, got);
    check_route(got, e);
  endtask : go

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  // hang guard, far beyond the few hundred cycles expected
  initial
  begin
    #20000;
    n_fail++;
    stop_test();
  end

  initial
  begin
    repeat (16) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    @(posedge i_core_clk);
    rd(FIXED_HOLE_OFS, FIXED_HOLE_RST);
    rd(SMM_RAM_OFS, SMM_RAM_RST);
    rd(8'h55, 8'h00);
    // random low and high dos traffic
    repeat (24)
    begin
      r = xorshift();
      vga <= r[31];
      go({13'h0, r[18:0]}, r[21:19], src_t'(r[23:22]), DEST_DRAM);
      go(HI_DOS_BASE + {15'h0, r[16:0]}, r[26:24], SRC_HOST, DEST_DRAM);
    end
    go(ISA_HOLE_BASE, 3'b000, SRC_HOST, DEST_DRAM);
    wr(FIXED_HOLE_OFS, 8'h80);
    rd(FIXED_HOLE_OFS, 8'h80);
    go(ISA_HOLE_BASE, 3'b100, SRC_HOST, DEST_PCI);
    go(ISA_HOLE_TOP, 3'b000, SRC_HOST, DEST_PCI);
    go(HI_DOS_TOP, 3'b000, SRC_HOST, DEST_PCI);
    go(HI_DOS_BASE, 3'b100, SRC_HOST, DEST_PCI);
    go(LOW_DOS_TOP, 3'b100, SRC_HOST, DEST_DRAM);
    // even segments read-only, odd read/write, top bios read-only
    wr(ATTR_MAP_BASE_OFS, 8'h10);
    rd(ATTR_MAP_BASE_OFS, 8'h10);
    wr(ATTR_MAP_LAST_OFS, 8'hff);
    rd(ATTR_MAP_LAST_OFS, 8'h33);
    for (int i = 1; i < ATTR_REGS; i++)
      wr(ATTR_MAP_BASE_OFS + 8'(i), 8'h31);
    rd(ATTR_MAP_LAST_OFS, 8'h31);
    for (int s = 0; s < SEG_COUNT; s++)
    begin
      r = xorshift();
      a = EXP_BASE + 32'(s) * 32'h4000 + {18'h0, r[13:0]};
      go(a, 3'b000, SRC_HOST, DEST_DRAM);
      go(a, 3'b100, SRC_HOST, s[0] ? DEST_DRAM : DEST_HUB);
      go(a, 3'b100, SRC_HUB, DEST_DRAM);
    end
    go(SYS_BIOS_BASE, 3'b000, SRC_HOST, DEST_DRAM);
    go(SYS_BIOS_TOP, 3'b100, SRC_HOST, DEST_HUB);
    // video range: vga route, then smm ram modes
    for (int v = 0; v < 2; v++)
    begin
      vga <= v[0];
      go(VIDEO_BASE, 3'b001, SRC_HOST, v[0] ? DEST_AGP : DEST_PCI);
    end
    wr(SMM_RAM_OFS, 8'h40);
    go(VIDEO_TOP, 3'b000, SRC_HOST, DEST_AGP);
    wr(SMM_RAM_OFS, 8'h48);
    rd(SMM_RAM_OFS, 8'h4a);
    go(VIDEO_BASE, 3'b000, SRC_PCI, DEST_AGP);
    go(VIDEO_TOP, 3'b100, SRC_HOST, DEST_DRAM);
    go(VIDEO_BASE, 3'b000, SRC_HUB, DEST_REFUSE);
    go(VIDEO_BASE, 3'b001, SRC_AGP, DEST_REFUSE);
    wr(SMM_RAM_OFS, 8'h28);
    go(VIDEO_BASE, 3'b001, SRC_HOST, DEST_HUB);
    go(VIDEO_BASE, 3'b011, SRC_HOST, DEST_DRAM);
    wr(SMM_RAM_OFS, 8'h08);
    go(VIDEO_BASE, 3'b101, SRC_HOST, DEST_DRAM);
    go(VIDEO_BASE, 3'b000, SRC_HOST, DEST_AGP);
    wr(SMM_RAM_OFS, 8'h18);
    rd(SMM_RAM_OFS, 8'h1a);
    wr(SMM_RAM_OFS, 8'h60);
    rd(SMM_RAM_OFS, 8'h3a);
    go(VIDEO_BASE, 3'b000, SRC_HOST, DEST_AGP);
    wr(SMM_RAM_OFS, 8'h00);
    rd(SMM_RAM_OFS, 8'h1a);
    // a full reset is the only way out of lock
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    @(posedge i_core_clk);
    rd(SMM_RAM_OFS, SMM_RAM_RST);
    rd(FIXED_HOLE_OFS, FIXED_HOLE_RST);
    stop_test();
  end
endmodule : testbench
